// ### rtl/mip_port.v
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "mip_defines.vh"
// Notes on behaviour
// R1 - Capture phase one on clock rise
// R2 - Capture phase two on ALE rise
// R3 - Host samples command line at ALE fall
// R4 - Host times command with command strobe
// R5 - Claim own cycle low while ALE high
// R6 - Signal pending request while ALE low
// R7 - Host acknowledges request with command strobe
// R8 - In stop clock, request restart asynchronously
// R9 - Tristate ready output extends cycles
// R10 - Strobe and select line are shared
// R11 - Bus reset clears interface state
// R12 - Bus carries address, command, data, requests
// R13 - Host repeats unchanged bits
// R14 - Decode ignores unchanged bit positions
// R15 - Memory cycles have cycle-type bit one
// R16 - Bit 0: cycle type, then write
// R17 - Bit 1: I/O-or-DMA, then high byte
// R18 - Bit 2 phase two: timing class
// R19 - Host drives rest of address second
// R20 - I/O cycles: type 0, I/O bit 1
// R21 - Host drops ALE on seeing claim
// R22 - Float outputs when idle
module mip_port
(
    input wire clk,
    input wire arst_n,
    input wire ale,
    input wire cmd_strobe_n,
    input wire [`MIP_BUS_W-1:0] mux_addr_data_bus_i,
    output reg [`MIP_BUS_W-1:0] mux_addr_data_bus_o,
    output reg mux_addr_data_bus_oe,
    output wire select_backoff_n_o,
    output wire select_backoff_n_oe,
    output wire iochrdy_o,
    output wire iochrdy_oe,
    input wire [`MIP_ADDR_W-1:0] mem_base,
    input wire [`MIP_ADDR_W-1:0] mem_mask,
    input wire [`MIP_ADDR_W-1:0] io_base,
    input wire [`MIP_ADDR_W-1:0] io_mask,
    input wire mem_enable,
    input wire io_enable,
    input wire req_pending,
    input wire stop_clock,
    input wire wait_request,
    input wire [`MIP_BUS_W-1:0] rd_data,
    output reg req_ack,
    output reg cyc_start,
    output reg cyc_write,
    output reg cyc_mem,
    output reg cyc_hbe_n,
    output reg cyc_fast,
    output reg [`MIP_ADDR_W-1:0] cyc_addr,
    output reg wr_valid,
    output reg [`MIP_BUS_W-1:0] wr_data
);
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_CLAIM = 4'h2;
    localparam [3:0] ST_DATA = 4'h4;
    localparam [3:0] ST_REQ = 4'h8;

    reg [3:0] state_q;
    reg [3:0] state_d;
    reg p1_mem_q;
    reg p1_io_q;
    reg [`MIP_BUS_W-1:0] p1_q;
    reg [`MIP_ADDR_W-1:0] addr_d;
    reg hit_d;
    reg cmd_seen_q;
    wire ale_rise;
    wire ale_fall;
    wire ale_q;
    wire cmd_fall;
    wire cmd_rise;
    wire cmd_q;

    mip_edge u_ale_edge
    (
        .clk(clk),
        .arst_n(arst_n),
        .din(ale),
        .rise(ale_rise),
        .fall(ale_fall),
        .level_q(ale_q)
    );

    mip_edge u_cmd_edge
    (
        .clk(clk),
        .arst_n(arst_n),
        .din(~cmd_strobe_n),
        .rise(cmd_fall),
        .fall(cmd_rise),
        .level_q(cmd_q)
    );

    // Phase one latched on each clock rise while ALE is low and the port is idle
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n) // [R11]
        begin
            p1_q <= {`MIP_BUS_W{1'b0}};
            p1_mem_q <= 1'b0;
            p1_io_q <= 1'b0;
        end
        else if (!ale && state_q == ST_IDLE)
        begin
            p1_q <= mux_addr_data_bus_i; // [R1]
            p1_mem_q <= mux_addr_data_bus_i[`MIP_P1_MIO_BIT]; // [R15] [R16]
            p1_io_q <= ~mux_addr_data_bus_i[`MIP_P1_MIO_BIT] &
                mux_addr_data_bus_i[`MIP_P1_IOD_BIT]; // [R17] [R20]
        end
    end

    // Address assembled from both phases; "same" positions never used
    always @*
    begin
        addr_d = `MIP_RST_ADDR;
        hit_d = 1'b0;
        if (p1_mem_q)
        begin
            addr_d = {p1_q[`MIP_MEM_A_HI:`MIP_MEM_A_LO],
                mux_addr_data_bus_i[`MIP_P2_MEMA_HI:`MIP_P2_MEMA_LO]}; // [R14]
            hit_d = mem_enable & (((addr_d ^ mem_base) & mem_mask) == `MIP_RST_ADDR);
        end
        else if (p1_io_q)
        begin
            addr_d = {8'h00, p1_q[`MIP_IO_MID_HI:`MIP_IO_MID_LO],
                p1_q[`MIP_IO_HI_HI:`MIP_IO_HI_LO],
                mux_addr_data_bus_i[`MIP_P2_IOA_HI:`MIP_P2_IOA_LO]}; // [R14] [R20]
            hit_d = io_enable & (((addr_d ^ io_base) & io_mask) == `MIP_RST_ADDR);
        end
    end

    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
                if (ale_rise && hit_d)
                    state_d = ST_CLAIM;
                else if (!ale && req_pending)
                    state_d = ST_REQ;
            ST_CLAIM:
                if (ale_fall || !ale)
                    state_d = ST_DATA;
            ST_DATA:
                if (cmd_seen_q && cmd_rise)
                    state_d = ST_IDLE;
            ST_REQ:
                if (ale || cmd_fall || !req_pending)
                    state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n) // [R11]
        begin
            state_q <= ST_IDLE;
            cmd_seen_q <= 1'b0;
            cyc_start <= 1'b0;
            cyc_write <= 1'b0;
            cyc_mem <= 1'b0;
            cyc_hbe_n <= 1'b1;
            cyc_fast <= 1'b0;
            cyc_addr <= `MIP_RST_ADDR;
            wr_valid <= 1'b0;
            wr_data <= {`MIP_BUS_W{1'b0}};
            req_ack <= 1'b0;
            mux_addr_data_bus_o <= {`MIP_BUS_W{1'b0}};
            mux_addr_data_bus_oe <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cyc_start <= 1'b0;
            wr_valid <= 1'b0;
            req_ack <= 1'b0;
            if (state_q == ST_IDLE && ale_rise && hit_d)
            begin
                cyc_start <= 1'b1; // [R2]
                cyc_write <= mux_addr_data_bus_i[`MIP_P2_WR_BIT]; // [R16]
                cyc_hbe_n <= mux_addr_data_bus_i[`MIP_P2_HBE_BIT]; // [R17]
                cyc_fast <= mux_addr_data_bus_i[`MIP_P2_TCLS_BIT]; // [R18]
                cyc_mem <= p1_mem_q;
                cyc_addr <= addr_d; // [R12]
            end
            if (state_q == ST_IDLE)
                cmd_seen_q <= 1'b0;
            else if (state_q == ST_DATA && cmd_fall)
                cmd_seen_q <= 1'b1; // [R4]
            // Write data taken as the strobe ends, when it is surely stable
            if (state_q == ST_DATA && cmd_rise && cyc_write)
            begin
                wr_valid <= 1'b1;
                wr_data <= mux_addr_data_bus_i;
            end
            // Live strobe, so the data stand on the bus by the host's next sampling edge
            if (state_q == ST_DATA && !cyc_write && !cmd_strobe_n)
            begin
                mux_addr_data_bus_o <= rd_data;
                mux_addr_data_bus_oe <= 1'b1;
            end
            else
                mux_addr_data_bus_oe <= 1'b0;
            if (state_q == ST_REQ && cmd_fall)
                req_ack <= 1'b1; // [R7]
        end
    end

    // Claim held while registered ALE high; request shown while ALE low; restart shown whenever stop_clock and req_pending
    wire claim_drv = (state_q == ST_CLAIM) & ale_q; // [R5] [R21]
    wire req_drv = (state_q == ST_REQ) & ~ale & req_pending; // [R6]
    wire wake_drv = stop_clock & req_pending; // [R8]
    assign select_backoff_n_o = 1'b0; // [R10]
    assign select_backoff_n_oe = claim_drv | req_drv | wake_drv; // [R22]

    // Ready pulled low only while extending our own data phase
    assign iochrdy_o = 1'b0; // [R9]
    assign iochrdy_oe = (state_q == ST_DATA) & cmd_q & wait_request; // [R9] [R22]
endmodule // mip_port
`default_nettype wire

// ### rtl/mip_defines.vh
`ifndef MIP_DEFINES_VH
`define MIP_DEFINES_VH
`define MIP_BUS_W 16
`define MIP_P1_MIO_BIT 0
`define MIP_P1_IOD_BIT 1
`define MIP_P2_WR_BIT 0
`define MIP_P2_HBE_BIT 1
`define MIP_P2_TCLS_BIT 2
`define MIP_MEM_A_HI 15
`define MIP_MEM_A_LO 2
`define MIP_P2_MEMA_HI 15
`define MIP_P2_MEMA_LO 6
`define MIP_IO_HI_HI 15
`define MIP_IO_HI_LO 8
`define MIP_IO_MID_HI 7
`define MIP_IO_MID_LO 2
`define MIP_P2_IOA_HI 7
`define MIP_P2_IOA_LO 6
`define MIP_ADDR_W 24
`define MIP_RST_ADDR 24'h000000
`endif

// ### rtl/mip_edge.v
`timescale 1ns/100ps
`default_nettype none
// Registers a level and flags its rising and falling edges
module mip_edge
(
    input wire clk,
    input wire arst_n,
    input wire din,
    output wire rise,
    output wire fall,
    output wire level_q
);
    reg prev_q;
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            prev_q <= 1'b0;
        else
            prev_q <= din;
    end
    assign rise = din & ~prev_q;
    assign fall = ~din & prev_q;
    assign level_q = prev_q;
endmodule // mip_edge
`default_nettype wire

// ### tb/mip_port_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module mip_port_monitor
(
    input wire clk,
    input wire arst_n,
    input wire ale,
    input wire cmd_strobe_n,
    input wire req_pending,
    input wire stop_clock,
    input wire select_backoff_n_o,
    input wire select_backoff_n_oe,
    input wire iochrdy_o,
    input wire iochrdy_oe,
    input wire mux_addr_data_bus_oe,
    input wire cyc_start,
    input wire req_ack,
    input wire wr_valid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    AST_LOW: assert property ((select_backoff_n_oe | iochrdy_oe) |-> !(select_backoff_n_o | iochrdy_o))
        else $error("high drive");
    AST_FLOAT: assert property (!req_pending && !$past(ale) |-> !select_backoff_n_oe) else $error("float");
    AST_START: assert property (cyc_start |-> $past(ale) && !$past(ale, 2)) else $error("start");
    AST_CLAIM: assert property (cyc_start |-> select_backoff_n_oe [*2]) else $error("claim");
    AST_WAKE: assert property (stop_clock && req_pending |-> select_backoff_n_oe) else $error("wake");
    AST_ACK: assert property (req_ack |-> !$past(cmd_strobe_n)) else $error("ack");
    AST_WR: assert property (wr_valid |-> $past(cmd_strobe_n) && !$past(cmd_strobe_n, 2)) else $error("wr");
    AST_RD: assert property (mux_addr_data_bus_oe |-> !$past(cmd_strobe_n) && !$past(ale)) else $error("rd");
    cover property (cyc_start);
    cover property (req_ack);
    cover property (iochrdy_oe ##1 !iochrdy_oe);
endmodule // mip_port_monitor
bind mip_port mip_port_monitor u_mon (.*);
`default_nettype wire

// ### tb/mip_host.sv
`timescale 1ns/100ps
`default_nettype none
module mip_host
(
    input wire clk,
    input wire sel_n,
    input wire rdy,
    input wire [15:0] bus,
    output logic ale = 1'b0,
    output logic cmd_n = 1'b1,
    output logic [15:0] drv = 16'h0000,
    output logic oe = 1'b0
);
    integer n;
    task cyc(input [15:0] p1, p2, d, output [15:0] q);
        @(posedge clk) {oe, drv} <= {1'b1, p1};
        @(posedge clk) {ale, drv} <= {1'b1, p2};
        @(posedge clk);
        for (n = 0; sel_n && n < 3; n++) @(posedge clk);
        {ale, oe, drv} <= {1'b0, p2[0], d}; // Reads hand the bus over
        if (!sel_n)
        begin
            @(posedge clk) cmd_n <= 1'b0;
            repeat (2) @(posedge clk);
            for (n = 0; !rdy && n < 50; n++) @(posedge clk);
            q = bus;
            cmd_n <= 1'b1;
        end
        @(posedge clk) oe <= 1'b0;
    endtask
    task ack;
        for (n = 0; sel_n && n < 20; n++) @(posedge clk);
        cmd_n <= 1'b0;
        @(posedge clk) cmd_n <= 1'b1;
    endtask
endmodule // mip_host
`default_nettype wire

// ### tb/mip_port_test.sv
`timescale 1ns/100ps
`default_nettype none
module mip_port_test;
    localparam [15:0] P1M = 16'hA405, P2W = 16'h5A3D, P1I = 16'h3456;
    logic clk = 1'b0, arst_n = 1'b0, mem_enable = 1'b0, io_enable = 1'b0, req_pending = 1'b0;
    logic stop_clock = 1'b0, wait_request = 1'b0;
    logic [15:0] lv = 16'h0000, wseen, q, rd_data = 16'hC3A5;
    logic [23:0] mem_base = 24'hA40000, io_base = {8'h00, P1I[7:2], P1I[15:8], 2'b00};
    wire ale, cmd_strobe_n, h_oe, mux_addr_data_bus_oe, select_backoff_n_o, select_backoff_n_oe, iochrdy_o;
    wire iochrdy_oe, req_ack, cyc_start, cyc_write, cyc_mem, cyc_hbe_n, cyc_fast, wr_valid;
    wire [15:0] drv, mux_addr_data_bus_o, wr_data;
    wire [23:0] cyc_addr;
    wire [27:0] cyc = {cyc_mem, cyc_write, cyc_hbe_n, cyc_fast, cyc_addr};
    wire sel_n = select_backoff_n_oe ? select_backoff_n_o : 1'b1; // Pull-up
    wire rdy = iochrdy_oe ? iochrdy_o : 1'b1;
    // Undriven bus keeps changing so a stale value cannot pass
    wire [15:0] mux_addr_data_bus_i = h_oe ? drv : mux_addr_data_bus_oe ? mux_addr_data_bus_o : ~lv;
    integer errors = 0, num_checks = 0, starts = 0, acks = 0;
    mip_port dut (.*, .mem_mask(24'hFF0000), .io_mask(24'hFFFFFC));
    mip_host host (.clk, .sel_n, .rdy, .bus(mux_addr_data_bus_i), .ale, .cmd_n(cmd_strobe_n), .drv, .oe(h_oe));
    always #5 clk = ~clk;
    always @(posedge clk)
    begin
        lv <= mux_addr_data_bus_i;
        starts <= starts + (cyc_start === 1'b1);
        acks <= acks + (req_ack === 1'b1);
        if (wr_valid === 1'b1) wseen <= wr_data;
    end
    task chk(input string nm, input [27:0] e, input [27:0] s);
        num_checks++;
        if (s !== e) $display("ERROR %0s exp %h seen %h", nm, e, s);
        errors += (s !== e);
    endtask
    task rst;
        arst_n <= 1'b0;
        repeat (10) @(posedge clk);
        chk("idle", 4'h8, {cyc_hbe_n, select_backoff_n_oe, iochrdy_oe, mux_addr_data_bus_oe});
        arst_n <= 1'b1;
    endtask
    task conclude(input integer bad);
        errors += bad;
        if (errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial #100000 conclude(1);
    initial
    begin
        rst;
        {mem_enable, io_enable} <= 2'b11;
        host.cyc(P1M, P2W, 16'h1234, q); // Unchanged positions flipped
        repeat (2) @(posedge clk);
        chk("mem", {4'hD, P1M[15:2], P2W[15:6]}, cyc);
        chk("wdata", 16'h1234, wseen);
        chk("start", 1, starts);
        rst;
        wait_request <= 1'b1;
        fork
            host.cyc(P1I, 16'h3452, 16'h0000, q); // Unchanged positions repeated
            #100 wait_request <= 1'b0;
        join
        chk("io", {4'h2, 8'h00, P1I[7:2], P1I[15:8], 2'b01}, cyc);
        chk("rdata", rd_data, q);
        host.cyc(16'hA406, P2W, 16'h0000, q); // Memory address, but typed as I/O
        chk("miss", 2, starts);
        req_pending <= 1'b1;
        repeat (2) @(posedge clk);
        chk("req", 1, select_backoff_n_oe);
        host.ack;
        req_pending <= 1'b0;
        repeat (2) @(posedge clk);
        chk("ack", 1, {select_backoff_n_oe, acks[3:0]});
        {stop_clock, req_pending} <= 2'b11;
        @(posedge clk);
        chk("wake", 1, select_backoff_n_oe);
        conclude(0);
    end
endmodule // mip_port_test
`default_nettype wire
